/* File: icm_modulator_top.sv */
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns

// How it works
// - Primary pairs 6 bits, secondary pairs 6 bits
// - Time mode always uses primary pair
// - FSK swaps pair at each mark expiry
// - Primary writes update count and output latch
// - Enable clear: latch drives infrared pin
// - Primary registers read back latch state
// - High write immediate, low write one cycle later
// - Reset clears the output latch
// - Mark down counter, underflow closes, compare space
// - Space match reopens gate, reloads from buffers
// - Zero space matches at once
// - Modulator timer runs from enable until the cycle in progress at disable ends
// - Period buffers reached through three byte registers
// - Time mode counts eight-clock units
// - Time mode: carrier starts at gate open, closes low; FSK runs it from enable through space
// - Baseband: high for mark, low for space
// - Half rate prescale doubles all durations
// - FSK counts carrier periods
// - Zero space FSK swaps frequency seamlessly
// - Extended space makes whole periods space
// - Clearing extended space resumes next period
// - Carrier timer is six-bit up counter
// - Enabled: modulator output drives infrared pin
// - Baseband stops carrier, holds it high
// - End of cycle sets flag, requests interrupt
module icm_modulator_top
	import icm_pkg::*;
#(
	parameter int AW = ADDR_W
)(
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          ce,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic               infrared_output_pin,
	output logic               cycle_end_irq
);

	// ----------------------------------------------------------------
	// Bus slave state
	// ----------------------------------------------------------------
	logic          aw_have_ff;
	logic          w_have_ff;
	logic [AW-1:0] aw_addr_ff;
	logic [7:0]    w_data_ff;
	logic          w_lane_ff;
	logic          bvalid_ff;
	logic [1:0]    bresp_ff;
	logic          rvalid_ff;
	logic [7:0]    rdata_ff;
	logic [1:0]    rresp_ff;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] primary_high_count_ff;
	logic [CNT_W-1:0] primary_low_count_ff;
	logic [CNT_W-1:0] secondary_high_count_ff;
	logic [CNT_W-1:0] secondary_low_count_ff;
	logic             latch_ff;
	logic             latch_pend_ff;
	logic             latch_pend_val_ff;
	logic             modulator_enable_ff;
	logic             ie_ff;
	logic             fsk_ff;
	logic             baseband_select_ff;
	logic             extended_space_enable_ff;
	logic             half_rate_prescale_ff;
	logic             eoc_ff;
	logic             eoc_armed_ff;
	logic [PER_W-1:0] mark_period_buffer_ff;
	logic [PER_W-1:0] space_period_buffer_ff;

	// ----------------------------------------------------------------
	// Modulator state
	// ----------------------------------------------------------------
	logic             run_ff;
	icm_phase_e       phase_ff;
	logic [PER_W-1:0] cnt_ff;
	logic [PER_W-1:0] active_space_period_ff;
	logic             gate_ff;
	logic             ext_ff;
	logic             sel_sec_ff;
	logic             div_ff;
	logic [2:0]       presc_ff;
	logic             pin_ff;

	icm_cg_if cg ();

	// ----------------------------------------------------------------
	// Write path
	// ----------------------------------------------------------------
	assign s_axi_awready = ~aw_have_ff & ~bvalid_ff;
	assign s_axi_wready  = ~w_have_ff & ~bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	wire wr_fire    = aw_have_ff & w_have_ff & ~bvalid_ff;
	wire wr_do      = wr_fire & w_lane_ff;
	wire wa_pri_hi  = (aw_addr_ff == OFF_PRI_HIGH);
	wire wa_pri_lo  = (aw_addr_ff == OFF_PRI_LOW);
	wire wa_sec_hi  = (aw_addr_ff == OFF_SEC_HIGH);
	wire wa_sec_lo  = (aw_addr_ff == OFF_SEC_LOW);
	wire wa_ctrl    = (aw_addr_ff == OFF_CTRL);
	wire wa_upper   = (aw_addr_ff == OFF_UPPER);
	wire wa_mark    = (aw_addr_ff == OFF_MARK_LO);
	wire wa_space   = (aw_addr_ff == OFF_SPACE_LO);
	wire wa_hit     = wa_pri_hi | wa_pri_lo | wa_sec_hi | wa_sec_lo | wa_ctrl | wa_upper | wa_mark | wa_space;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			aw_addr_ff <= '0;
			w_data_ff  <= 8'h00;
			w_lane_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_ff <= 1'b1;
				w_data_ff <= s_axi_wdata[7:0];
				w_lane_ff <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_have_ff <= 1'b0;
				w_have_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wa_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff  <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = {24'h000000, rdata_ff};

	wire rd_fire   = s_axi_arvalid & ~rvalid_ff;
	wire ra_pri_hi = (s_axi_araddr == OFF_PRI_HIGH);
	wire ra_pri_lo = (s_axi_araddr == OFF_PRI_LOW);
	wire ra_sec_hi = (s_axi_araddr == OFF_SEC_HIGH);
	wire ra_sec_lo = (s_axi_araddr == OFF_SEC_LOW);
	wire ra_ctrl   = (s_axi_araddr == OFF_CTRL);
	wire ra_upper  = (s_axi_araddr == OFF_UPPER);
	wire ra_mark   = (s_axi_araddr == OFF_MARK_LO);
	wire ra_space  = (s_axi_araddr == OFF_SPACE_LO);

	wire [7:0] ctrl_rd = {eoc_ff, half_rate_prescale_ff, 1'b0, extended_space_enable_ff,
		baseband_select_ff, fsk_ff, ie_ff, modulator_enable_ff};

	logic [7:0] rd_mux;
	logic       rd_hit;
	always_comb begin
		rd_mux = 8'h00;
		rd_hit = 1'b1;
		if (ra_pri_hi) begin
			rd_mux = {latch_ff, 1'b0, primary_high_count_ff};
		end else if (ra_pri_lo) begin
			rd_mux = {latch_ff, 1'b0, primary_low_count_ff};
		end else if (ra_sec_hi) begin
			rd_mux = {2'b00, secondary_high_count_ff};
		end else if (ra_sec_lo) begin
			rd_mux = {2'b00, secondary_low_count_ff};
		end else if (ra_ctrl) begin
			rd_mux = ctrl_rd;
		end else if (ra_upper) begin
			rd_mux = {mark_period_buffer_ff[PER_W-1 -: NIB_W], space_period_buffer_ff[PER_W-1 -: NIB_W]};
		end else if (ra_mark) begin
			rd_mux = mark_period_buffer_ff[7:0];
		end else if (ra_space) begin
			rd_mux = space_period_buffer_ff[7:0];
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 8'h00;
			rresp_ff  <= RESP_OKAY;
		end else if (ce) begin
			if (rd_fire) begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= rd_mux;
				rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register writes and latch
	// ----------------------------------------------------------------
	// Flag clear needs a control read, then any access of a period low byte
	wire ctrl_read    = rd_fire & ra_ctrl;
	wire period_touch = (rd_fire & (ra_mark | ra_space)) | (wr_fire & (wa_mark | wa_space));
	wire eoc_clear    = eoc_armed_ff & period_touch;
	logic cycle_end;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			primary_high_count_ff    <= CNT_RST;
			primary_low_count_ff     <= CNT_RST;
			secondary_high_count_ff  <= CNT_RST;
			secondary_low_count_ff   <= CNT_RST;
			latch_ff                 <= 1'b0;
			latch_pend_ff            <= 1'b0;
			latch_pend_val_ff        <= 1'b0;
			modulator_enable_ff      <= 1'b0;
			ie_ff                    <= 1'b0;
			fsk_ff                   <= 1'b0;
			baseband_select_ff       <= 1'b0;
			extended_space_enable_ff <= 1'b0;
			half_rate_prescale_ff    <= 1'b0;
			eoc_ff                   <= 1'b0;
			eoc_armed_ff             <= 1'b0;
			mark_period_buffer_ff    <= PER_RST;
			space_period_buffer_ff   <= PER_RST;
		end else if (ce) begin
			latch_pend_ff <= 1'b0;
			if (latch_pend_ff) begin
				latch_ff <= latch_pend_val_ff;
			end
			if (wr_do && wa_pri_hi) begin
				primary_high_count_ff <= w_data_ff[CNT_W-1:0];
				latch_ff              <= w_data_ff[LATCH_BIT];
			end
			if (wr_do && wa_pri_lo) begin
				primary_low_count_ff <= w_data_ff[CNT_W-1:0];
				latch_pend_ff        <= 1'b1;
				latch_pend_val_ff    <= w_data_ff[LATCH_BIT];
			end
			if (wr_do && wa_sec_hi) begin
				secondary_high_count_ff <= w_data_ff[CNT_W-1:0];
			end
			if (wr_do && wa_sec_lo) begin
				secondary_low_count_ff <= w_data_ff[CNT_W-1:0];
			end
			if (wr_do && wa_ctrl) begin
				modulator_enable_ff      <= w_data_ff[BIT_EN];
				ie_ff                    <= w_data_ff[BIT_IE];
				fsk_ff                   <= w_data_ff[BIT_FSK];
				baseband_select_ff       <= w_data_ff[BIT_BASEBAND_SELECT];
				extended_space_enable_ff <= w_data_ff[BIT_EXTENDED_SPACE_ENABLE];
				half_rate_prescale_ff    <= w_data_ff[BIT_HALF_RATE_PRESCALE];
			end
			if (wr_do && wa_upper) begin
				mark_period_buffer_ff[PER_W-1 -: NIB_W]  <= w_data_ff[7:4];
				space_period_buffer_ff[PER_W-1 -: NIB_W] <= w_data_ff[3:0];
			end
			if (wr_do && wa_mark) begin
				mark_period_buffer_ff[7:0] <= w_data_ff;
			end
			if (wr_do && wa_space) begin
				space_period_buffer_ff[7:0] <= w_data_ff;
			end
			if (ctrl_read) begin
				eoc_armed_ff <= 1'b1;
			end else if (period_touch) begin
				eoc_armed_ff <= 1'b0;
			end
			// A new end of cycle beats a clear in the same cycle
			if (cycle_end) begin
				eoc_ff <= 1'b1;
			end else if (eoc_clear) begin
				eoc_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Prescale and modulator
	// ----------------------------------------------------------------
	wire baseband_select_tick = run_ff & (~half_rate_prescale_ff | div_ff);
	wire time_tick = baseband_select_tick & (presc_ff == PRESC_LAST);
	wire mod_tick  = fsk_ff ? cg.period_done : time_tick;
	wire mark_end  = (phase_ff == ICM_MARK) & mod_tick & (cnt_ff == PER_RST);
	assign cycle_end = run_ff & (phase_ff == ICM_SPACE) & (~cnt_ff == active_space_period_ff);
	wire start     = modulator_enable_ff & ~run_ff;
	// Time mode closes on a low carrier, or at once in baseband; FSK ends mark on a low carrier already
	wire gate_shut = (phase_ff == ICM_SPACE) & (baseband_select_ff | ~cg.carrier);

	assign cg.tick          = baseband_select_tick;
	assign cg.run           = run_ff & ~baseband_select_ff & (fsk_ff | gate_ff);
	assign cg.use_secondary = fsk_ff & sel_sec_ff;
	assign cg.pri_high      = primary_high_count_ff;
	assign cg.pri_low       = primary_low_count_ff;
	assign cg.sec_high      = secondary_high_count_ff;
	assign cg.sec_low       = secondary_low_count_ff;

	wire mod_out = gate_ff & (baseband_select_ff | cg.carrier);
	wire pin_nxt = modulator_enable_ff ? mod_out : latch_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_ff                 <= 1'b0;
			phase_ff               <= ICM_MARK;
			cnt_ff                 <= PER_RST;
			active_space_period_ff <= PER_RST;
			gate_ff                <= 1'b0;
			ext_ff                 <= 1'b0;
			sel_sec_ff             <= 1'b0;
			div_ff                 <= 1'b0;
			presc_ff               <= PRESC_RST;
			pin_ff                 <= 1'b0;
		end else if (ce) begin
			pin_ff <= pin_nxt;
			div_ff <= run_ff & ~div_ff;
			if (baseband_select_tick) begin
				presc_ff <= presc_ff + PRESC_ONE;
			end
			if (start) begin
				run_ff                 <= 1'b1;
				phase_ff               <= ICM_MARK;
				cnt_ff                 <= mark_period_buffer_ff;
				active_space_period_ff <= space_period_buffer_ff;
				ext_ff                 <= extended_space_enable_ff;
				gate_ff                <= ~extended_space_enable_ff;
				sel_sec_ff             <= 1'b0;
				presc_ff               <= PRESC_RST;
				div_ff                 <= 1'b0;
			end else if (cycle_end) begin
				// Disable takes effect only once the running cycle has expired
				run_ff                 <= modulator_enable_ff;
				phase_ff               <= ICM_MARK;
				cnt_ff                 <= mark_period_buffer_ff;
				active_space_period_ff <= space_period_buffer_ff;
				ext_ff                 <= extended_space_enable_ff;
				gate_ff                <= modulator_enable_ff & ~extended_space_enable_ff;
			end else if (run_ff) begin
				if (mod_tick) begin
					cnt_ff <= cnt_ff - PER_ONE;
				end
				if (mark_end) begin
					phase_ff <= ICM_SPACE;
					if (fsk_ff) begin
						sel_sec_ff <= ~sel_sec_ff;
						// Zero space keeps the gate open so the swap leaves no gap
						gate_ff    <= ~ext_ff & (active_space_period_ff == PER_RST);
					end
				end else if (gate_shut && !fsk_ff) begin
					gate_ff <= 1'b0;
				end else if (gate_shut && ext_ff) begin
					gate_ff <= 1'b0;
				end
			end
		end
	end

	assign infrared_output_pin = pin_ff;
	assign cycle_end_irq       = eoc_ff & ie_ff;

	icm_carrier_gen u_carrier (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.cg      (cg.gen)
	);

endmodule : icm_modulator_top

/* File: icm_pkg.sv */
package icm_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int          ADDR_W        = 5;
	localparam logic [4:0]  OFF_PRI_HIGH  = 5'h00;
	localparam logic [4:0]  OFF_PRI_LOW   = 5'h04;
	localparam logic [4:0]  OFF_SEC_HIGH  = 5'h08;
	localparam logic [4:0]  OFF_SEC_LOW   = 5'h0c;
	localparam logic [4:0]  OFF_CTRL      = 5'h10;
	localparam logic [4:0]  OFF_UPPER     = 5'h14;
	localparam logic [4:0]  OFF_MARK_LO   = 5'h18;
	localparam logic [4:0]  OFF_SPACE_LO  = 5'h1c;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int          LATCH_BIT     = 7;
	localparam int          CNT_W         = 6;
	localparam int          PER_W         = 12;
	localparam int          NIB_W         = 4;
	localparam int          BIT_EN        = 0;
	localparam int          BIT_IE        = 1;
	localparam int          BIT_FSK       = 2;
	localparam int          BIT_BASEBAND_SELECT      = 3;
	localparam int          BIT_EXTENDED_SPACE_ENABLE     = 4;
	localparam int          BIT_HALF_RATE_PRESCALE      = 6;
	localparam int          BIT_EOC       = 7;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [5:0]  CNT_RST       = 6'h00;
	localparam logic [5:0]  CNT_ONE       = 6'h01;
	localparam logic [11:0] PER_RST       = 12'h000;
	localparam logic [11:0] PER_ONE       = 12'h001;
	localparam logic [2:0]  PRESC_LAST    = 3'h7;
	localparam logic [2:0]  PRESC_ONE     = 3'h1;
	localparam logic [2:0]  PRESC_RST     = 3'h0;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic {
		ICM_MARK  = 1'b0,
		ICM_SPACE = 1'b1
	} icm_phase_e;

endpackage : icm_pkg

/* File: icm_cg_if.sv */
`timescale 1ns/1ns
interface icm_cg_if;
	import icm_pkg::*;
	logic             tick;
	logic             run;
	logic             use_secondary;
	logic [CNT_W-1:0] pri_high;
	logic [CNT_W-1:0] pri_low;
	logic [CNT_W-1:0] sec_high;
	logic [CNT_W-1:0] sec_low;
	logic             carrier;
	logic             period_done;

	modport gen (input tick, run, use_secondary, pri_high, pri_low, sec_high, sec_low,
		output carrier, period_done);
	modport ctl (output tick, run, use_secondary, pri_high, pri_low, sec_high, sec_low,
		input carrier, period_done);
endinterface : icm_cg_if

/* File: icm_carrier_gen.sv */
`timescale 1ns/1ns
module icm_carrier_gen
	import icm_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	icm_cg_if.gen     cg
);

	logic [CNT_W-1:0] cnt_ff;
	logic             high_ff;

	wire  [CNT_W-1:0] high_cnt = cg.use_secondary ? cg.sec_high : cg.pri_high;
	wire  [CNT_W-1:0] low_cnt  = cg.use_secondary ? cg.sec_low : cg.pri_low;
	wire  [CNT_W-1:0] target   = high_ff ? high_cnt : low_cnt;
	wire  [CNT_W-1:0] cnt_inc  = cnt_ff + CNT_ONE;
	wire              hit      = cg.run & cg.tick & (cnt_inc == target);

	// Period ends as the low phase completes, while the carrier is still low
	assign cg.period_done = hit & ~high_ff;
	assign cg.carrier     = high_ff;

	// Stopped generator rests high so a fresh start opens with a full high time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff  <= CNT_RST;
			high_ff <= 1'b1;
		end else if (ce) begin
			if (!cg.run) begin
				cnt_ff  <= CNT_RST;
				high_ff <= 1'b1;
			end else if (hit) begin
				cnt_ff  <= CNT_RST;
				high_ff <= ~high_ff;
			end else if (cg.tick) begin
				cnt_ff  <= cnt_inc;
			end
		end
	end

endmodule : icm_carrier_gen

/* File: icm_modulator_top_sva.sv */
`timescale 1ns/1ns
module icm_modulator_top_chk
	import icm_pkg::*;
#(
	parameter int AW = ADDR_W
)(
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic          ce,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic [31:0]   s_axi_wdata,
	input wire logic [3:0]    s_axi_wstrb,
	input wire logic          s_axi_wvalid,
	input wire logic          s_axi_wready,
	input wire logic [1:0]    s_axi_bresp,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic [31:0]   s_axi_rdata,
	input wire logic [1:0]    s_axi_rresp,
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready,
	input wire logic          infrared_output_pin,
	input wire logic          cycle_end_irq
);
	// ----------------------------------------------------------------
	// Bus timing
	// ----------------------------------------------------------------
	AST_WRITE_TWO_EDGES: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce ##1 ce |-> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not on second edge");
	AST_BVALID_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && s_axi_bready && ce |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write response not retired");
	AST_WR_BLOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	AST_READ_ONE_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
		else $error("read data late");
	AST_RVALID_ONE_BEAT: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && s_axi_rready && ce |=> !s_axi_rvalid && s_axi_arready)
		else $error("read data not retired");
	AST_RD_BLOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	AST_RDATA_BYTE: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && (s_axi_rresp != RESP_SLVERR || s_axi_rdata == 32'h0))
		else $error("read data outside byte lane");
	// Reset is the cause here, so it cannot also disable
	AST_RESET_QUIET: assert property (@(posedge aclk)
		!aresetn && ce |=> !infrared_output_pin && !cycle_end_irq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs active after reset edge");
endmodule : icm_modulator_top_chk

bind icm_modulator_top icm_modulator_top_chk #(.AW(AW)) u_chk (
	.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.infrared_output_pin(infrared_output_pin), .cycle_end_irq(cycle_end_irq));

/* File: icm_emitter_model.sv */
`timescale 1ns/1ns
// Emitter load: measures run lengths of the drive level in clocks
module icm_emitter_model (
	input  wire logic aclk,
	input  wire logic ir_drive,
	output int        hi_last,
	output int        hi_prev,
	output int        lo_last,
	output int        edges,
	output int        chg_cyc
);
	int   cnt_ff = 0;
	int   run_ff = 0;
	logic lvl_ff = 1'b0;

	always @(posedge aclk) begin
		cnt_ff <= cnt_ff + 1;
		if (ir_drive !== lvl_ff) begin
			if (lvl_ff) begin
				hi_prev <= hi_last;
				hi_last <= run_ff;
				edges   <= edges + 1;
			end else begin
				lo_last <= run_ff;
			end
			run_ff  <= 1;
			lvl_ff  <= ir_drive;
			chg_cyc <= cnt_ff;
		end else begin
			run_ff <= run_ff + 1;
		end
	end
endmodule : icm_emitter_model

/* File: ir_carrier_modulator_tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module ir_carrier_modulator_tb_top
	import icm_pkg::*;
;
	localparam int AW = 6;
	localparam logic [7:0] MSK [9] = '{8'hbf, 8'hbf, 8'h3f, 8'h3f, 8'h5f, 8'hff, 8'hff, 8'hff, 8'h00};
	logic          aclk, aresetn, ce;
	logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]   s_axi_wdata, s_axi_rdata;
	logic [3:0]    s_axi_wstrb;
	logic [1:0]    s_axi_bresp, s_axi_rresp;
	logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic          s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic          infrared_output_pin, cycle_end_irq;
	logic [7:0]    mir [9] = '{default: 8'h00};
	int            num_errors = 0;
	int            total_checks = 0;
	int            cyc = 0;
	int            wr_cyc, hi_last, hi_prev, lo_last, edges, chg_cyc;

	icm_modulator_top #(.AW(AW)) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.infrared_output_pin(infrared_output_pin), .cycle_end_irq(cycle_end_irq));
	icm_emitter_model u_emit (.aclk(aclk), .ir_drive(infrared_output_pin), .hi_last(hi_last),
		.hi_prev(hi_prev), .lo_last(lo_last), .edges(edges), .chg_cyc(chg_cyc));

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk) cyc <= cyc + 1;

	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	// ----------------------------------------------------------------
	// Bus master, each access starts on a fresh rising edge
	// ----------------------------------------------------------------
	task automatic wr(input int i, input logic [7:0] d, input logic [3:0] s = 4'hf);
		logic [1:0] r;
		logic       ta, tw, tb;
		int         n;
		@(posedge aclk);
		s_axi_awaddr  <= AW'(i * 4);
		s_axi_wdata   <= {24'h0, d};
		s_axi_wstrb   <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			r  = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) break;
		end
		wr_cyc = cyc;
		if (n == 50) begin
			num_errors++;
			summarize();
		end
		`CHK("bresp", (i > 7) ? RESP_SLVERR : RESP_OKAY, r)
		if (i < 8 && s[0]) begin
			mir[i] = d & MSK[i];
			if (i < 2) begin
				mir[0][7] = d[7];
				mir[1][7] = d[7];
			end
		end
	endtask : wr

	task automatic rd(input int i, output logic [7:0] v);
		logic [31:0] dt;
		logic [1:0]  r;
		logic        tr, rv;
		int          n;
		@(posedge aclk);
		s_axi_araddr  <= AW'(i * 4);
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge aclk);
			tr = s_axi_arvalid & s_axi_arready;
			rv = s_axi_rvalid;
			dt = s_axi_rdata;
			r  = s_axi_rresp;
			@(posedge aclk);
			if (tr) s_axi_arvalid <= 1'b0;
			if (rv) break;
		end
		if (n == 50) begin
			num_errors++;
			summarize();
		end
		v = dt[7:0];
		`CHK("rresp", (i > 7) ? RESP_SLVERR : RESP_OKAY, r)
		`CHK("rdata", {24'h0, mir[i] & ((i == 4) ? 8'h7f : 8'hff)}, dt & ((i == 4) ? 32'h7f : 32'hffffffff))
	endtask : rd

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] v;
		int         k, i, saved;
		aresetn = 1'b0;
		ce = 1'b1;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = '0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		void'($urandom(45));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (k = 0; k < 9; k++) rd(k, v);
		`CHK("pin", 1'b0, infrared_output_pin)
		for (k = 0; k < 16; k++) begin
			i = $urandom_range(7);
			if (i == 4) i = 8;
			wr(i, 8'($urandom));
			rd(i, v);
		end
		wr(2, 8'h15);
		wr(2, 8'h2a, 4'h0);
		rd(2, v);
		wr(1, 8'h00);
		wr(0, 8'h83);
		repeat (3) @(negedge aclk);
		`CHK("pin", 1'b1, infrared_output_pin)
		`CHK("hi_latch_delay", 1, chg_cyc - wr_cyc)
		rd(1, v);
		wr(1, 8'h05);
		repeat (3) @(negedge aclk);
		`CHK("pin", 1'b0, infrared_output_pin)
		`CHK("lo_latch_delay", 2, chg_cyc - wr_cyc)
		// Nonzero counts before any enable
		wr(0, 8'h03);
		wr(2, 8'h02);
		wr(3, 8'h02);
		wr(5, 8'h00);
		wr(6, 8'hff);
		wr(7, 8'h00);
		wr(4, 8'h01);
		repeat (200) @(negedge aclk);
		`CHK("carrier_high", 3, hi_last)
		`CHK("carrier_low", 5, lo_last)
		@(posedge aclk) ce <= 1'b0;
		repeat (2) @(posedge aclk);
		saved = edges;
		repeat (40) @(posedge aclk);
		`CHK("ce_freeze", saved, edges)
		ce <= 1'b1;
		wr(4, 8'h00);
		// Long mark must expire before mode bits may change
		repeat (2200) @(negedge aclk);
		`CHK("pin", 1'b0, infrared_output_pin)
		wr(6, 8'h00);
		wr(4, 8'h05);
		repeat (200) @(negedge aclk);
		`CHK("fsk_pair_sum", 5, hi_last + hi_prev)
		`CHK("fsk_alternates", 1, int'(hi_last != hi_prev))
		wr(4, 8'h00);
		repeat (100) @(negedge aclk);
		wr(6, 8'h02);
		wr(7, 8'h01);
		wr(4, 8'h0b);
		repeat (200) @(negedge aclk);
		`CHK("mark_len", 24, hi_last)
		`CHK("space_len", 8, lo_last)
		`CHK("irq", 1'b1, cycle_end_irq)
		wr(4, 8'h00);
		repeat (100) @(negedge aclk);
		wr(4, 8'h4b);
		repeat (400) @(negedge aclk);
		`CHK("mark_len_half", 48, hi_last)
		`CHK("space_len_half", 16, lo_last)
		wr(4, 8'h5b);
		repeat (150) @(negedge aclk);
		saved = edges;
		repeat (300) @(negedge aclk);
		`CHK("exspace_pulses", saved, edges)
		`CHK("pin", 1'b0, infrared_output_pin)
		wr(4, 8'h4b);
		repeat (300) @(negedge aclk);
		`CHK("resumed", 1, int'(edges > saved))
		wr(4, 8'h02);
		repeat (200) @(negedge aclk);
		rd(4, v);
		`CHK("eoc_flag", 1'b1, v[7])
		`CHK("irq", 1'b1, cycle_end_irq)
		rd(6, v);
		repeat (2) @(negedge aclk);
		`CHK("irq", 1'b0, cycle_end_irq)
		summarize();
	end
endmodule : ir_carrier_modulator_tb_top
